// ---- hw/dnc_ctrl.sv ----
`timescale 1ns/1ns
module dnc_ctrl #(
  parameter int RES_BITS = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [4:0] nvm_addr,
  output logic nvm_we,
  output logic nvm_re,
  output logic [31:0] nvm_wdata,
  input wire logic [31:0] nvm_rdata,
  input wire logic nvm_ready,
  output logic [7:0] voltage_path_powerdown_sel,
  output logic [3:0] current_path_powerdown,
  output logic int_ref_on,
  output logic mode_input_off,
  output logic [3:0] ref_ext_sel,
  output logic [11:0] voltage_gain_ref_sel,
  output logic [3:0] vout_mode,
  output logic [3:0] iout_mode,
  output logic [4*RES_BITS-1:0] channel_code,
  output logic [31:0] channel_code_byte,
  output logic [15:0] current_span_sel,
  output logic [47:0] margin_high,
  output logic [47:0] margin_low,
  output logic [3:0] sense_hiz,
  input wire logic [3:0] cmp_above_code,
  input wire logic [3:0] cmp_above_high,
  input wire logic [3:0] cmp_below_low,
  output logic [3:0] cmp_result,
  output logic [3:0] channel_output_pin_o,
  output logic [3:0] channel_output_pin_oe
);
  localparam int NW = dnc_pkg::NW;
  localparam int NCH = dnc_pkg::NCH;
  localparam logic [31:0] DATA_MSK = (32'h00000001 << RES_BITS) - 32'h00000001;

  if (RES_BITS != 10 && RES_BITS != 12) begin : g_chk
    $error("RES_BITS must be 10 or 12.");
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] wmask(input logic [4:0] idx);
    if (idx == dnc_pkg::IDX_COMMON) begin
      return dnc_pkg::MSK_COMMON;
    end else if (idx == dnc_pkg::IDX_MODE) begin
      return dnc_pkg::MSK_MODE;
    end else if (idx < dnc_pkg::IDX_CCFG0) begin
      return dnc_pkg::MSK_VCFG;
    end else if (idx < dnc_pkg::IDX_DATA0) begin
      return dnc_pkg::MSK_CCFG;
    end else if (idx < dnc_pkg::IDX_MARGIN0) begin
      return DATA_MSK;
    end else begin
      return dnc_pkg::MSK_MARGIN;
    end
  endfunction

  function automatic logic [2:0] gain_of(input logic [2:0] sel);
    if (sel > dnc_pkg::GAIN_X4) begin
      return dnc_pkg::GAIN_EXT_X1;
    end else begin
      return sel;
    end
  endfunction

  // ==========================================
  // Storage and sequencer
  logic [31:0] cfg_r [NW];
  logic busy;
  logic storing;
  logic loading;
  logic [4:0] seq_idx;
  logic ld_we;
  logic [31:0] ld_data;
  logic store_go;
  logic load_go;

  dnc_nvm_seq #(
    .NW(NW)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .store_go(store_go),
    .load_go(load_go),
    .word_rd(cfg_r[seq_idx]),
    .busy(busy),
    .storing(storing),
    .loading(loading),
    .word_idx(seq_idx),
    .ld_we(ld_we),
    .ld_data(ld_data),
    .nvm_addr(nvm_addr),
    .nvm_we(nvm_we),
    .nvm_re(nvm_re),
    .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata),
    .nvm_ready(nvm_ready)
  );

  // ==========================================
  // APB slave, one wait state per transfer
  logic ack_r;
  logic err_r;
  logic [31:0] prdata_r;
  logic [4:0] a_idx;
  logic in_array;
  logic mapped;
  logic wr_ok;
  logic [31:0] status_word;

  assign a_idx = paddr[6:2];
  assign in_array = (paddr[1:0] == 2'h0) && !paddr[7] && (a_idx < 5'(NW));
  assign mapped = in_array || paddr == dnc_pkg::OFS_TRIG || paddr == dnc_pkg::OFS_STATUS;
  assign wr_ok = psel && penable && ack_r && pwrite && !err_r;
  assign store_go = wr_ok && paddr == dnc_pkg::OFS_TRIG && pwdata[dnc_pkg::TRIG_STORE_BIT];
  assign load_go = wr_ok && paddr == dnc_pkg::OFS_TRIG && !pwdata[dnc_pkg::TRIG_STORE_BIT]
                   && pwdata[dnc_pkg::TRIG_LOAD_BIT];
  assign pready = ack_r;
  assign pslverr = ack_r && err_r;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= psel && penable && !ack_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (psel && penable && !ack_r) begin
      err_r <= busy || !mapped;
      if (busy || !mapped || pwrite) begin
        prdata_r <= 32'h00000000;
      end else if (in_array) begin
        prdata_r <= cfg_r[a_idx];
      end else if (paddr == dnc_pkg::OFS_TRIG) begin
        prdata_r <= {30'h00000000, loading, storing};
      end else begin
        prdata_r <= status_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NW; i++) begin
        cfg_r[i] <= (i == 0) ? dnc_pkg::RST_COMMON : dnc_pkg::RST_OTHER;
      end
    end else if (ld_we) begin
      cfg_r[seq_idx] <= ld_data & wmask(seq_idx);
    end else if (wr_ok && in_array) begin
      cfg_r[a_idx] <= pwdata & wmask(a_idx);
    end
  end

  // ==========================================
  // Channel decode
  logic [3:0] cmp_active;
  logic [3:0] pin_lvl;
  logic [3:0] drive_on;
  logic [3:0] od_sel;
  logic [1:0] style [NCH];
  logic [31:0] com;

  assign com = cfg_r[dnc_pkg::IDX_COMMON];
  assign voltage_path_powerdown_sel = com[dnc_pkg::COM_VPDN_LSB +: 8];
  assign current_path_powerdown = com[dnc_pkg::COM_IPDN_LSB +: 4];
  assign int_ref_on = com[dnc_pkg::COM_INTREF_BIT];
  assign mode_input_off = cfg_r[dnc_pkg::IDX_MODE][dnc_pkg::MODE_OFF_BIT];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic [31:0] vc;
      logic [31:0] cc;
      logic [31:0] mg;
      logic [1:0] vp;
      vc = cfg_r[5'(dnc_pkg::IDX_VCFG0 + c)];
      cc = cfg_r[5'(dnc_pkg::IDX_CCFG0 + c)];
      mg = cfg_r[5'(dnc_pkg::IDX_MARGIN0 + c)];
      vp = com[dnc_pkg::COM_VPDN_LSB + 2*c +: 2];
      vout_mode[c] = vp == dnc_pkg::VPDN_UP && com[dnc_pkg::COM_IPDN_LSB + c];
      iout_mode[c] = vp == dnc_pkg::VPDN_HIZ && !com[dnc_pkg::COM_IPDN_LSB + c];
      voltage_gain_ref_sel[3*c +: 3] = gain_of(vc[dnc_pkg::VC_GAIN_LSB +: 3]);
      ref_ext_sel[c] = gain_of(vc[dnc_pkg::VC_GAIN_LSB +: 3]) == dnc_pkg::GAIN_EXT_X1;
      channel_code[RES_BITS*c +: RES_BITS] = cfg_r[5'(dnc_pkg::IDX_DATA0 + c)][RES_BITS-1:0];
      channel_code_byte[8*c +: 8] = cc[dnc_pkg::CC_BYTE_LSB +: 8];
      current_span_sel[4*c +: 4] = cc[dnc_pkg::CC_SPAN_LSB +: 4];
      margin_low[12*c +: 12] = mg[dnc_pkg::MG_LOW_LSB +: 12];
      margin_high[12*c +: 12] = mg[dnc_pkg::MG_HIGH_LSB +: 12];
      sense_hiz[c] = !vc[dnc_pkg::VC_HIZOFF_BIT];
      cmp_active[c] = vout_mode[c] && vc[dnc_pkg::VC_CMPON_BIT];
      drive_on[c] = cmp_active[c] && vc[dnc_pkg::VC_DRIVE_BIT];
      od_sel[c] = vc[dnc_pkg::VC_OD_BIT];
      pin_lvl[c] = cmp_result[c] ^ vc[dnc_pkg::VC_INV_BIT];
      style[c] = vc[dnc_pkg::VC_STYLE_LSB +: 2];
    end
  end

  // ==========================================
  // Comparator result per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_result <= 4'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!cmp_active[c]) begin
          cmp_result[c] <= 1'b0;
        end else begin
          case (style[c])
            dnc_pkg::STY_HYST: begin
              if (cmp_above_high[c]) begin
                cmp_result[c] <= 1'b1;
              end else if (cmp_below_low[c]) begin
                cmp_result[c] <= 1'b0;
              end
            end
            dnc_pkg::STY_WINDOW: begin
              cmp_result[c] <= !cmp_above_high[c] && !cmp_below_low[c];
            end
            default: begin
              cmp_result[c] <= cmp_above_code[c];
            end
          endcase
        end
      end
    end
  end

  // ==========================================
  // Output pin drive
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      channel_output_pin_o[c] = od_sel[c] ? 1'b0 : pin_lvl[c];
      channel_output_pin_oe[c] = drive_on[c] && (!od_sel[c] || !pin_lvl[c]);
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[dnc_pkg::ST_VMODE_LSB +: 4] = vout_mode;
    status_word[dnc_pkg::ST_IMODE_LSB +: 4] = iout_mode;
    status_word[dnc_pkg::ST_CMP_LSB +: 4] = cmp_result;
    status_word[dnc_pkg::ST_BUSY_BIT] = busy;
  end

  // ==========================================
  // Assertions
  AST_STORE_START: assert property (@(posedge pclk) disable iff (!presetn)
    store_go |=> nvm_we && busy && nvm_addr == 5'h00)
    else $error("Store trigger did not start a store walk.");

  AST_SELF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (storing && nvm_ready && nvm_addr == 5'(NW - 1)) |=> !busy && !storing)
    else $error("Store trigger did not clear after the last word.");

  AST_WALK_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    busy && nvm_ready && nvm_addr != 5'(NW - 1) |=> busy && nvm_addr == $past(nvm_addr) + 5'h01)
    else $error("Memory walk did not advance by one word.");

  AST_LOAD_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    (loading && nvm_ready && nvm_addr == 5'(NW - 1)) |=> !busy && !loading)
    else $error("Reload trigger did not clear after the last word.");

  AST_RELOAD_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_we && seq_idx == dnc_pkg::IDX_MODE)
    |=> cfg_r[dnc_pkg::IDX_MODE] == ($past(nvm_rdata) & dnc_pkg::MSK_MODE))
    else $error("Reloaded word did not land in its register.");

  AST_BUSY_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !ack_r && busy) ##1 (psel && penable) |-> pslverr && prdata == 32'h00000000)
    else $error("Access during a memory cycle was not refused.");

  AST_BUSY_NOWRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && pslverr && pwrite && !ld_we) |=> $stable(cfg_r[dnc_pkg::IDX_COMMON]))
    else $error("Refused write changed a register.");

  AST_GAIN_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    ref_ext_sel[0] |-> voltage_gain_ref_sel[2:0] == dnc_pkg::GAIN_EXT_X1)
    else $error("External reference without unity gain.");

  AST_GAIN_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_r[dnc_pkg::IDX_VCFG0][dnc_pkg::VC_GAIN_LSB +: 3] > dnc_pkg::GAIN_X4
    |-> ref_ext_sel[0] && voltage_gain_ref_sel[2:0] == dnc_pkg::GAIN_EXT_X1)
    else $error("Unused gain code did not fall back to unity.");

  AST_CMP_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_active[0] |=> !cmp_result[0] && !channel_output_pin_oe[0] || cmp_active[0])
    else $error("Inactive comparator showed a result.");

  AST_PIN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_r[dnc_pkg::IDX_VCFG0][dnc_pkg::VC_DRIVE_BIT] |-> !channel_output_pin_oe[0])
    else $error("Pin driven with drive enable clear.");

  AST_OPEN_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
    od_sel[1] && channel_output_pin_oe[1] |-> !channel_output_pin_o[1])
    else $error("Open-drain pin drove high.");

  AST_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_active[2] && style[2] == dnc_pkg::STY_WINDOW && !cmp_above_high[2] && !cmp_below_low[2]
    ##1 cmp_active[2] |-> cmp_result[2])
    else $error("Window comparison missed an in-window input.");

  AST_BAD_STYLE: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_active[3] && style[3] == dnc_pkg::STY_BAD ##1 cmp_active[3]
    |-> cmp_result[3] == $past(cmp_above_code[3]))
    else $error("Invalid style did not act as normal comparison.");
endmodule

// ---- hw/dnc_pkg.sv ----
package dnc_pkg;
  // ==========================================
  // Sizes
  localparam int NCH = 4;
  localparam int NW = 18;
  // ==========================================
  // Register offsets and word indices
  localparam logic [4:0] IDX_COMMON = 5'h00;
  localparam logic [4:0] IDX_MODE = 5'h01;
  localparam logic [4:0] IDX_VCFG0 = 5'h02;
  localparam logic [4:0] IDX_CCFG0 = 5'h06;
  localparam logic [4:0] IDX_DATA0 = 5'h0A;
  localparam logic [4:0] IDX_MARGIN0 = 5'h0E;
  localparam logic [7:0] OFS_TRIG = 8'h48;
  localparam logic [7:0] OFS_STATUS = 8'h4C;
  // ==========================================
  // Field positions
  localparam int COM_VPDN_LSB = 0;
  localparam int COM_IPDN_LSB = 8;
  localparam int COM_INTREF_BIT = 12;
  localparam int MODE_OFF_BIT = 0;
  localparam int VC_GAIN_LSB = 0;
  localparam int VC_CMPON_BIT = 3;
  localparam int VC_OD_BIT = 4;
  localparam int VC_DRIVE_BIT = 5;
  localparam int VC_INV_BIT = 6;
  localparam int VC_HIZOFF_BIT = 7;
  localparam int VC_STYLE_LSB = 8;
  localparam int CC_SPAN_LSB = 0;
  localparam int CC_BYTE_LSB = 8;
  localparam int MG_LOW_LSB = 0;
  localparam int MG_HIGH_LSB = 16;
  localparam int TRIG_STORE_BIT = 0;
  localparam int TRIG_LOAD_BIT = 1;
  localparam int ST_VMODE_LSB = 0;
  localparam int ST_IMODE_LSB = 4;
  localparam int ST_CMP_LSB = 8;
  localparam int ST_BUSY_BIT = 12;
  // ==========================================
  // Reset values and writable masks
  localparam logic [31:0] RST_COMMON = 32'h00000FFF;
  localparam logic [31:0] RST_OTHER = 32'h00000000;
  localparam logic [31:0] MSK_COMMON = 32'h00001FFF;
  localparam logic [31:0] MSK_MODE = 32'h00000001;
  localparam logic [31:0] MSK_VCFG = 32'h000003FF;
  localparam logic [31:0] MSK_CCFG = 32'h0000FF0F;
  localparam logic [31:0] MSK_MARGIN = 32'h0FFF0FFF;
  // ==========================================
  // Field encodings
  localparam logic [1:0] VPDN_UP = 2'h0;
  localparam logic [1:0] VPDN_HIZ = 2'h3;
  localparam logic [1:0] STY_NORMAL = 2'h0;
  localparam logic [1:0] STY_HYST = 2'h1;
  localparam logic [1:0] STY_WINDOW = 2'h2;
  localparam logic [1:0] STY_BAD = 2'h3;
  localparam logic [2:0] GAIN_EXT_X1 = 3'h0;
  localparam logic [2:0] GAIN_X1P5 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X3 = 3'h3;
  localparam logic [2:0] GAIN_X4 = 3'h4;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_STORE, SEQ_LOAD} dnc_seq_type;
endpackage

// ---- hw/dnc_nvm_seq.sv ----
`timescale 1ns/1ns
module dnc_nvm_seq #(
  parameter int NW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic store_go,
  input wire logic load_go,
  input wire logic [31:0] word_rd,
  output logic busy,
  output logic storing,
  output logic loading,
  output logic [4:0] word_idx,
  output logic ld_we,
  output logic [31:0] ld_data,
  output logic [4:0] nvm_addr,
  output logic nvm_we,
  output logic nvm_re,
  output logic [31:0] nvm_wdata,
  input wire logic [31:0] nvm_rdata,
  input wire logic nvm_ready
);
  localparam logic [4:0] LAST = 5'(NW - 1);

  if (NW < 1 || NW > 32) begin : g_chk
    $error("NW must lie between 1 and 32.");
  end

  dnc_pkg::dnc_seq_type state_r;
  logic [4:0] idx_r;

  // ==========================================
  // Word walk over the image, one word per memory handshake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= dnc_pkg::SEQ_LOAD;
      idx_r <= 5'h00;
    end else begin
      case (state_r)
        dnc_pkg::SEQ_IDLE: begin
          if (store_go) begin
            state_r <= dnc_pkg::SEQ_STORE;
          end else if (load_go) begin
            state_r <= dnc_pkg::SEQ_LOAD;
          end
        end
        default: begin
          if (nvm_ready) begin
            if (idx_r == LAST) begin
              state_r <= dnc_pkg::SEQ_IDLE;
              idx_r <= 5'h00;
            end else begin
              idx_r <= idx_r + 5'h01;
            end
          end
        end
      endcase
    end
  end

  assign storing = (state_r == dnc_pkg::SEQ_STORE);
  assign loading = (state_r == dnc_pkg::SEQ_LOAD);
  assign busy = storing | loading;
  assign word_idx = idx_r;
  assign nvm_addr = idx_r;
  assign nvm_we = storing;
  assign nvm_re = loading;
  assign nvm_wdata = word_rd;
  assign ld_we = loading & nvm_ready;
  assign ld_data = nvm_rdata;
endmodule

// ---- dv/dnc_nvm_model.sv ----
`timescale 1ns/1ns
module dnc_nvm_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [4:0] nvm_addr,
  input wire logic nvm_we,
  input wire logic nvm_re,
  input wire logic [31:0] nvm_wdata,
  output logic [31:0] nvm_rdata,
  output logic nvm_ready
);
  // ==========================================
  // Storage and answer timing
  logic [31:0] mem [0:17];
  logic [2:0] wait_r;
  initial begin
    for (int i = 1; i < 18; i++) mem[i] = 32'h00000000;
    mem[0] = 32'h00000FFF;
  end
  // Read data is only valid in the ready cycle; otherwise its inverse shows.
  assign nvm_rdata = nvm_ready ? mem[nvm_addr] : ~mem[nvm_addr];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 3'h0;
      nvm_ready <= 1'b0;
    end else begin
      nvm_ready <= 1'b0;
      if ((nvm_we || nvm_re) && !nvm_ready) begin
        if (wait_r >= (slow ? 3'h4 : 3'h0)) begin
          nvm_ready <= 1'b1;
          wait_r <= 3'h0;
        end else begin
          wait_r <= wait_r + 3'h1;
        end
      end
    end
  end
  always @(posedge pclk) begin
    if (nvm_we && nvm_ready) mem[nvm_addr] <= nvm_wdata;
  end
endmodule

// ---- dv/dnc_ctrl_tb.sv ----
`timescale 1ns/1ns
module dnc_ctrl_tb;
  localparam int RB = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_we, nvm_re, nvm_ready, slow;
  logic int_ref_on, mode_input_off, busy_m, cmp_chk;
  logic [7:0] paddr, voltage_path_powerdown_sel;
  logic [31:0] pwdata, prdata, nvm_wdata, nvm_rdata, channel_code_byte;
  logic [4:0] nvm_addr;
  logic [3:0] current_path_powerdown, ref_ext_sel, vout_mode, iout_mode, sense_hiz, cmp_result, pin_o, pin_oe;
  logic [3:0] above_code, above_high, below_low, res_m;
  logic [11:0] voltage_gain_ref_sel;
  logic [4*RB-1:0] channel_code;
  logic [15:0] current_span_sel;
  logic [47:0] margin_high, margin_low;
  logic [31:0] mdl [0:17];
  logic [31:0] nv [0:17];
  int mismatches, total_checks;

  dnc_ctrl #(.RES_BITS(RB)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_addr(nvm_addr), .nvm_we(nvm_we), .nvm_re(nvm_re), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
    .nvm_ready(nvm_ready), .voltage_path_powerdown_sel(voltage_path_powerdown_sel),
    .current_path_powerdown(current_path_powerdown), .int_ref_on(int_ref_on), .mode_input_off(mode_input_off),
    .ref_ext_sel(ref_ext_sel), .voltage_gain_ref_sel(voltage_gain_ref_sel), .vout_mode(vout_mode),
    .iout_mode(iout_mode), .channel_code(channel_code), .channel_code_byte(channel_code_byte),
    .current_span_sel(current_span_sel), .margin_high(margin_high), .margin_low(margin_low),
    .sense_hiz(sense_hiz), .cmp_above_code(above_code), .cmp_above_high(above_high),
    .cmp_below_low(below_low), .cmp_result(cmp_result), .channel_output_pin_o(pin_o),
    .channel_output_pin_oe(pin_oe));
  dnc_nvm_model nvm (.pclk(pclk), .presetn(presetn), .slow(slow), .nvm_addr(nvm_addr), .nvm_we(nvm_we),
    .nvm_re(nvm_re), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ready(nvm_ready));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========================================
  // Reference model
  function automatic logic [31:0] msk(int i);
    if (i == 0) return dnc_pkg::MSK_COMMON;
    if (i == 1) return dnc_pkg::MSK_MODE;
    if (i < 6) return dnc_pkg::MSK_VCFG;
    if (i < 10) return dnc_pkg::MSK_CCFG;
    if (i < 14) return (32'h00000001 << RB) - 32'h00000001;
    return dnc_pkg::MSK_MARGIN;
  endfunction
  function automatic logic vm(int c);
    return mdl[0][2*c+:2] == 2'h0 && mdl[0][8+c];
  endfunction
  function automatic logic im(int c);
    return mdl[0][2*c+:2] == 2'h3 && !mdl[0][8+c];
  endfunction
  function automatic logic nxt(int c);
    if (!(vm(c) && mdl[2+c][3])) return 1'b0;
    case (mdl[2+c][9:8])
      2'h1: return above_high[c] ? 1'b1 : (below_low[c] ? 1'b0 : res_m[c]);
      2'h2: return !above_high[c] && !below_low[c];
      default: return above_code[c];
    endcase
  endfunction
  function automatic logic [31:0] rnd(int i);
    logic [31:0] v;
    v = $urandom;
    if (i >= 2 && i < 6 && v[31]) v[2:0] = 3'($urandom % 5);
    return v;
  endfunction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) res_m <= 4'h0;
    else for (int c = 0; c < 4; c++) res_m[c] <= nxt(c);
  end
  always @(posedge pclk) begin
    above_code <= 4'($urandom);
    above_high <= 4'($urandom);
    below_low <= 4'($urandom) & ~4'($urandom) & ~above_high;
  end

  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge pclk) begin
    if (cmp_chk) begin
      logic [3:0] eo, eoe, act;
      for (int c = 0; c < 4; c++) begin
        act[c] = vm(c) && mdl[2+c][3];
        eoe[c] = act[c] && mdl[2+c][5] && (!mdl[2+c][4] || !(res_m[c] ^ mdl[2+c][6]));
        eo[c] = eoe[c] && !mdl[2+c][4] && (res_m[c] ^ mdl[2+c][6]);
      end
      chk("cmp", cmp_result, res_m);
      chk("oe", pin_oe, eoe);
      chk("o", pin_o & eoe, eo);
    end
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
    int n;
    logic ee;
    n = 0;
    ee = busy_m || a > 8'h4C || a[1:0] != 2'h0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    chk("pslverr", pslverr, ee);
    if (ee) chk("prdata", prdata, 0);
    if (w && !ee && a < 8'h48) mdl[a[6:2]] <= d & msk(int'(a[6:2]));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk_outs();
    @(negedge pclk);
    for (int c = 0; c < 4; c++) begin
      chk("vmode", vout_mode[c], vm(c));
      chk("imode", iout_mode[c], im(c));
      chk("ext", ref_ext_sel[c], mdl[2+c][2:0] == 3'h0 || mdl[2+c][2:0] > 3'h4);
      chk("gain", voltage_gain_ref_sel[3*c+:3], (mdl[2+c][2:0] > 3'h4) ? 3'h0 : mdl[2+c][2:0]);
      chk("hiz", sense_hiz[c], !mdl[2+c][7]);
      chk("span", current_span_sel[4*c+:4], mdl[6+c][3:0]);
      chk("byte", channel_code_byte[8*c+:8], mdl[6+c][15:8]);
      chk("code", channel_code[RB*c+:RB], mdl[10+c][RB-1:0]);
      chk("mhi", margin_high[12*c+:12], mdl[14+c][27:16]);
      chk("mlo", margin_low[12*c+:12], mdl[14+c][11:0]);
    end
    chk("iref", int_ref_on, mdl[0][12]);
    chk("modeoff", mode_input_off, mdl[1][0]);
    chk("vpdn", voltage_path_powerdown_sel, mdl[0][7:0]);
    chk("ipdn", current_path_powerdown, mdl[0][11:8]);
    @(posedge pclk);
  endtask
  task automatic chk_all();
    logic [31:0] r;
    for (int i = 0; i < 18; i++) begin
      apb(8'(4 * i), 1'b0, 32'h00000000, r);
      chk("reg", r, mdl[i]);
    end
    chk_outs();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((nvm_we || nvm_re) && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      final_report();
    end
    busy_m = 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset();
    logic [31:0] r;
    cmp_chk = 1'b0;
    busy_m = 1'b1;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 18; i++) mdl[i] <= nv[i];
    apb(8'h04, 1'b1, 32'h00000001, r);
    wait_idle();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] d;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    slow = 1'b0;
    above_code = 4'h0;
    above_high = 4'h0;
    below_low = 4'h0;
    mismatches = 0;
    total_checks = 0;
    for (int i = 0; i < 18; i++) nv[i] = 32'h00000000;
    nv[0] = 32'h00000FFF;
    r = $urandom(95);
    do_reset();
    chk_all();
    cmp_chk = 1'b1;
    repeat (3) begin
      for (int i = 0; i < 18; i++) apb(8'(4 * i), 1'b1, rnd(i), r);
      apb(8'h28, 1'b1, 32'hFFFFFFFF, r);
      apb(8'h50, 1'b1, 32'h00000001, r);
      apb(8'h05, 1'b1, 32'h00000001, r);
      apb(8'h4C, 1'b1, 32'h00000001, r);
      chk_all();
    end
    apb(8'h00, 1'b1, 32'h000000FF, r);
    apb(8'h4C, 1'b0, 32'h00000000, r);
    chk("status", r & 32'h000010FF, 32'h000000F0);
    apb(8'h00, 1'b1, 32'h00001F00, r);
    repeat (30) begin
      for (int c = 0; c < 4; c++) begin
        d = ($urandom & 32'h000003F0) | 32'h00000008 | ($urandom % 5);
        apb(8'(8 + 4 * c), 1'b1, d, r);
      end
      repeat (6) @(posedge pclk);
    end
    apb(8'h4C, 1'b0, 32'h00000000, r);
    chk("status", r & 32'h000010FF, 32'h0000000F);
    cmp_chk = 1'b0;
    slow <= 1'b1;
    apb(8'h48, 1'b1, 32'h00000001, r);
    busy_m = 1'b1;
    for (int i = 0; i < 18; i++) nv[i] = mdl[i];
    apb(8'h04, 1'b1, 32'h00000001, r);
    apb(8'h00, 1'b0, 32'h00000000, r);
    wait_idle();
    slow <= 1'b0;
    for (int i = 0; i < 18; i++) chk("nvm", nvm.mem[i], nv[i]);
    apb(8'h48, 1'b0, 32'h00000000, r);
    chk("trig", r, 32'h00000000);
    chk_all();
    for (int i = 0; i < 18; i++) apb(8'(4 * i), 1'b1, rnd(i), r);
    apb(8'h48, 1'b1, 32'h00000002, r);
    busy_m = 1'b1;
    wait_idle();
    for (int i = 0; i < 18; i++) mdl[i] <= nv[i];
    apb(8'h48, 1'b0, 32'h00000000, r);
    chk("trig", r, 32'h00000000);
    chk_all();
    for (int i = 0; i < 18; i++) apb(8'(4 * i), 1'b1, rnd(i), r);
    do_reset();
    chk_all();
    final_report();
  end
endmodule
